// ===== inc/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// configuration port pair
`define WDT_INDEX_PORT 16'h002e
`define WDT_DATA_PORT 16'h002f

// index-port key values
`define WDT_UNLOCK_KEY 8'h87
`define WDT_LOCK_KEY 8'haa

// register indices
`define WDT_REG_BANK 8'h07
`define WDT_REG_ACTIVATE 8'h30
`define WDT_REG_UNIT 8'hf5
`define WDT_REG_COUNT 8'hf6
`define WDT_REG_CTRL 8'hf7

// bank value that selects the watchdog registers
`define WDT_BANK_WATCHDOG 8'h08

// field positions
`define WDT_ACT_ENABLE_BIT 0
`define WDT_UNIT_MINUTE_BIT 3
`define WDT_UNIT_FAST_BIT 4
`define WDT_CTRL_STATUS_BIT 4
`define WDT_CTRL_FORCE_BIT 5
`define WDT_CTRL_KBD_BIT 6
`define WDT_CTRL_MOUSE_BIT 7

// reset values, then fixed read data for locked and unmapped reads
`define WDT_BANK_RST 8'h00
`define WDT_ACTIVATE_RST 8'h00
`define WDT_UNIT_RST 8'h00
`define WDT_COUNT_RST 8'h00
`define WDT_CTRL_RST 8'h00
`define WDT_LOCKED_RDATA 8'hff
`define WDT_UNMAPPED_RDATA 8'h00

// timing
`define WDT_CLK_PERIOD_NS 50
`define WDT_MS_NS 1000000
`define WDT_MS_CYCLES (`WDT_MS_NS / `WDT_CLK_PERIOD_NS)
`define WDT_FAST_DIV 1000
`define WDT_MINUTE_DIV 60

`endif

// ===== inc/wdt_pkg.sv
package wdt_pkg;

    typedef enum logic [1:0] {
        CFG_LOCKED,
        CFG_HALF_KEY,
        CFG_OPEN
    } cfg_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } io_req_type;

    typedef struct packed {
        logic mouseEn;
        logic kbdEn;
        logic fast;
        logic minutes;
        logic enable;
    } wdt_cfg_type;

endpackage

// ===== hw/unit_tick_gen.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

module unit_tick_gen #(
    parameter int unsigned MS_CYCLES = `WDT_MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // control
    input wire logic restart,
    input wire logic minutes,
    input wire logic fast,
    // tick out
    output logic unitTick
);
    logic [24:0] cycCnt_q, cycCnt_d;
    logic [15:0] msCnt_q, msCnt_d;
    logic msTick;
    logic [15:0] msPerUnit;

    // ms per unit: 1, 60, 1000 or 60000
    always_comb begin
        case ({minutes, fast})
            2'b01: msPerUnit = 16'h0001;
            2'b11: msPerUnit = 16'(`WDT_MINUTE_DIV);
            2'b00: msPerUnit = 16'(`WDT_FAST_DIV);
            default: msPerUnit = 16'(`WDT_FAST_DIV * `WDT_MINUTE_DIV);
        endcase
    end

    always_comb begin
        msTick = (cycCnt_q == 25'(MS_CYCLES - 1));
        cycCnt_d = msTick ? 25'h0000000 : cycCnt_q + 25'h0000001;
        msCnt_d = msCnt_q;
        unitTick = 1'b0;
        if (msTick) begin
            if (msCnt_q == msPerUnit - 16'h0001) begin
                unitTick = 1'b1;
                msCnt_d = 16'h0000;
            end else begin
                msCnt_d = msCnt_q + 16'h0001;
            end
        end
        if (restart) begin
            cycCnt_d = 25'h0000000;
            msCnt_d = 16'h0000;
            unitTick = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cycCnt_q <= 25'h0000000;
            msCnt_q <= 16'h0000;
        end else begin
            cycCnt_q <= cycCnt_d;
            msCnt_q <= msCnt_d;
        end
    end
endmodule // unit_tick_gen

// ===== hw/indexed_watchdog_timer.sv
// Function
// [R1] index port latches index, data port transfers
// [R2] host writes index before data access
// [R3] two successive unlock keys open configuration
// [R4] bank value selects watchdog register bank
// [R5] activation bit enables; disabled after reset
// [R6] unit bit3: seconds clear, minutes set
// [R7] unit bit4 makes ticks thousand times faster
// [R8] zero count holds timer stopped; reset zero
// [R9] nonzero count sets units before timeout
// [R10] count write restarts countdown from value
// [R11] control bit6 lets keyboard restart countdown
// [R12] control bit5 forces timeout, self clears
// [R13] control bit4 reads timeout status
// [R14] single lock key closes configuration
// [R15] control bit7 lets mouse restart countdown
// [R16] data writes ignored while locked
// [R17] decrement per tick, stop expired until rewrite
`timescale 1ns/1ps
`include "wdt_defs.svh"

module indexed_watchdog_timer #(
    parameter int unsigned MS_CYCLES = `WDT_MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // host i/o access
    input wire wdt_pkg::io_req_type ioReq,
    output logic [7:0] ioRdData,
    // activity strobes
    input wire logic kbdActivity,
    input wire logic mouseActivity,
    // timeout
    output logic timeoutOut,
    output logic timeoutStatus
);
    // ---------------- access decode
    logic idxWr, dataWr, dataRd;
    wdt_pkg::cfg_state_type cfgState_q, cfgState_d;
    logic [7:0] index_q, index_d;
    logic [7:0] bank_q, bank_d;
    logic cfgOpen;
    logic wdtWr;

    function automatic logic isWatchdogIdx(input logic [7:0] idx);
        isWatchdogIdx = (idx == `WDT_REG_ACTIVATE) || (idx == `WDT_REG_UNIT)
            || (idx == `WDT_REG_COUNT) || (idx == `WDT_REG_CTRL);
    endfunction

    always_comb begin
        idxWr = ioReq.wr && (ioReq.addr == `WDT_INDEX_PORT); // [R1]
        dataWr = ioReq.wr && (ioReq.addr == `WDT_DATA_PORT); // [R1]
        dataRd = ioReq.rd && (ioReq.addr == `WDT_DATA_PORT); // [R1]
        cfgOpen = (cfgState_q == wdt_pkg::CFG_OPEN);
        // watchdog registers reachable only when open and bank selected
        wdtWr = dataWr && cfgOpen && (bank_q == `WDT_BANK_WATCHDOG); // [R4] [R16]
    end

    // ---------------- lock state machine
    always_comb begin
        cfgState_d = cfgState_q;
        case (cfgState_q)
            wdt_pkg::CFG_LOCKED: begin
                if (idxWr && ioReq.data == `WDT_UNLOCK_KEY) begin
                    cfgState_d = wdt_pkg::CFG_HALF_KEY; // [R3]
                end
            end
            wdt_pkg::CFG_HALF_KEY: begin
                if (idxWr && ioReq.data == `WDT_UNLOCK_KEY) begin
                    cfgState_d = wdt_pkg::CFG_OPEN; // [R3]
                end else if (idxWr || dataWr || dataRd) begin
                    cfgState_d = wdt_pkg::CFG_LOCKED; // [R3]
                end
            end
            wdt_pkg::CFG_OPEN: begin
                if (idxWr && ioReq.data == `WDT_LOCK_KEY) begin
                    cfgState_d = wdt_pkg::CFG_LOCKED; // [R14]
                end
            end
            default: cfgState_d = wdt_pkg::CFG_LOCKED;
        endcase
    end

    // ---------------- index and bank
    always_comb begin
        index_d = index_q;
        bank_d = bank_q;
        if (idxWr && cfgOpen && ioReq.data != `WDT_LOCK_KEY) begin
            index_d = ioReq.data; // [R1] [R2]
        end
        if (dataWr && cfgOpen && index_q == `WDT_REG_BANK) begin
            bank_d = ioReq.data; // [R4]
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfgState_q <= wdt_pkg::CFG_LOCKED;
            index_q <= 8'h00;
            bank_q <= `WDT_BANK_RST;
        end else begin
            cfgState_q <= cfgState_d;
            index_q <= index_d;
            bank_q <= bank_d;
        end
    end

    // ---------------- watchdog configuration registers
    logic [7:0] activate_q, activate_d;
    logic [7:0] unit_q, unit_d;
    logic [7:0] count_q, count_d;
    logic kbdEn_q, kbdEn_d;
    logic mouseEn_q, mouseEn_d;
    logic countWr, ctrlWr;
    wdt_pkg::wdt_cfg_type cfg;

    always_comb begin
        countWr = wdtWr && (index_q == `WDT_REG_COUNT);
        ctrlWr = wdtWr && (index_q == `WDT_REG_CTRL);
        activate_d = activate_q;
        unit_d = unit_q;
        count_d = count_q;
        kbdEn_d = kbdEn_q;
        mouseEn_d = mouseEn_q;
        if (wdtWr && index_q == `WDT_REG_ACTIVATE) begin
            activate_d = ioReq.data; // [R5]
        end
        if (wdtWr && index_q == `WDT_REG_UNIT) begin
            unit_d = ioReq.data; // [R6] [R7]
        end
        if (countWr) begin
            count_d = ioReq.data; // [R9]
        end
        if (ctrlWr) begin
            kbdEn_d = ioReq.data[`WDT_CTRL_KBD_BIT]; // [R11]
            mouseEn_d = ioReq.data[`WDT_CTRL_MOUSE_BIT]; // [R15]
        end
        cfg.enable = activate_q[`WDT_ACT_ENABLE_BIT]; // [R5]
        cfg.minutes = unit_q[`WDT_UNIT_MINUTE_BIT]; // [R6]
        cfg.fast = unit_q[`WDT_UNIT_FAST_BIT]; // [R7]
        cfg.kbdEn = kbdEn_q;
        cfg.mouseEn = mouseEn_q;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            activate_q <= `WDT_ACTIVATE_RST; // [R5]
            unit_q <= `WDT_UNIT_RST; // [R6]
            count_q <= `WDT_COUNT_RST; // [R8]
            kbdEn_q <= 1'(`WDT_CTRL_RST >> `WDT_CTRL_KBD_BIT); // [R11]
            mouseEn_q <= 1'(`WDT_CTRL_RST >> `WDT_CTRL_MOUSE_BIT); // [R15]
        end else begin
            activate_q <= activate_d;
            unit_q <= unit_d;
            count_q <= count_d;
            kbdEn_q <= kbdEn_d;
            mouseEn_q <= mouseEn_d;
        end
    end

    // ---------------- countdown
    logic [7:0] remain_q, remain_d;
    logic expired_q, expired_d;
    logic forceTo;
    logic activityRestart;
    logic restart;
    logic unitTick;
    logic running;
    logic expireNow;

    always_comb begin
        // force bit acts on the write itself, never stored
        forceTo = ctrlWr && ioReq.data[`WDT_CTRL_FORCE_BIT]; // [R12]
        activityRestart = !expired_q && ((cfg.kbdEn && kbdActivity) // [R11]
            || (cfg.mouseEn && mouseActivity)); // [R15]
        restart = countWr || activityRestart; // [R10]
        running = cfg.enable && (count_q != 8'h00) && (remain_q != 8'h00)
            && !expired_q; // [R8] [R17]
        expireNow = running && unitTick && (remain_q == 8'h01); // [R9]
        remain_d = remain_q;
        if (countWr) begin
            remain_d = ioReq.data; // [R10]
        end else if (activityRestart) begin
            remain_d = count_q; // [R11] [R15]
        end else if (running && unitTick) begin
            remain_d = remain_q - 8'h01; // [R17]
        end
        // set wins over the clear done by a count rewrite
        expired_d = expired_q;
        if (expireNow || forceTo) begin
            expired_d = 1'b1; // [R12] [R17]
        end else if (countWr) begin
            expired_d = 1'b0; // [R17]
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            remain_q <= `WDT_COUNT_RST;
            expired_q <= 1'b0;
        end else begin
            remain_q <= remain_d;
            expired_q <= expired_d;
        end
    end

    unit_tick_gen #(
        .MS_CYCLES(MS_CYCLES)
    ) tickGen (
        .clock(clock),
        .nrst(nrst),
        .restart(restart || !running),
        .minutes(cfg.minutes),
        .fast(cfg.fast),
        .unitTick(unitTick)
    );

    assign timeoutOut = expired_q; // [R9] [R12]
    assign timeoutStatus = expired_q; // [R13]

    // ---------------- read data
    logic [7:0] rdData_q, rdData_d;
    logic [7:0] ctrlRead;

    always_comb begin
        ctrlRead = 8'h00;
        ctrlRead[`WDT_CTRL_MOUSE_BIT] = mouseEn_q;
        ctrlRead[`WDT_CTRL_KBD_BIT] = kbdEn_q;
        ctrlRead[`WDT_CTRL_STATUS_BIT] = expired_q; // [R13]
        rdData_d = rdData_q;
        if (dataRd) begin
            if (!cfgOpen) begin
                rdData_d = `WDT_LOCKED_RDATA; // [R16]
            end else if (index_q == `WDT_REG_BANK) begin
                rdData_d = bank_q;
            end else if (bank_q != `WDT_BANK_WATCHDOG || !isWatchdogIdx(index_q)) begin
                rdData_d = `WDT_UNMAPPED_RDATA;
            end else begin
                case (index_q)
                    `WDT_REG_ACTIVATE: rdData_d = activate_q;
                    `WDT_REG_UNIT: rdData_d = unit_q;
                    `WDT_REG_COUNT: rdData_d = remain_q;
                    `WDT_REG_CTRL: rdData_d = ctrlRead;
                    default: rdData_d = `WDT_UNMAPPED_RDATA;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    assign ioRdData = rdData_q;
endmodule // indexed_watchdog_timer

// ===== dv/indexed_watchdog_timer_sva.sv
`timescale 1ns/1ps
module wdt_checker (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // host access
    input wire wdt_pkg::io_req_type ioReq,
    input wire logic [7:0] ioRdData,
    // activity and timeout
    input wire logic kbdActivity,
    input wire logic mouseActivity,
    input wire logic timeoutOut,
    input wire logic timeoutStatus
);
    logic [1:0] key_q, key_d;
    logic [7:0] idx_q, idx_d, bank_q, bank_d;
    logic idxWr, datWr, wdWr, cntWr, frcWr;
    assign idxWr = ioReq.wr && ioReq.addr == 16'h002e;
    assign datWr = ioReq.wr && ioReq.addr == 16'h002f;
    assign wdWr = datWr && key_q == 2'h2 && bank_q == 8'h08;
    assign cntWr = wdWr && idx_q == 8'hf6;
    assign frcWr = wdWr && idx_q == 8'hf7 && ioReq.data[5];
    // shadow of the unlock state, index and bank
    always_comb begin
        key_d = key_q;
        idx_d = idx_q;
        bank_d = bank_q;
        if (key_q != 2'h2 && idxWr && ioReq.data == 8'h87) key_d = key_q + 2'h1;
        else if (key_q == 2'h1 && (idxWr || datWr || (ioReq.rd && ioReq.addr == 16'h002f)))
            key_d = 2'h0;
        if (key_q == 2'h2 && idxWr && ioReq.data == 8'haa) key_d = 2'h0;
        else if (key_q == 2'h2 && idxWr) idx_d = ioReq.data;
        if (datWr && key_q == 2'h2 && idx_q == 8'h07) bank_d = ioReq.data;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            key_q <= 2'h0;
            idx_q <= 8'h00;
            bank_q <= 8'h00;
        end else begin
            key_q <= key_d;
            idx_q <= idx_d;
            bank_q <= bank_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_zeroWr;
        cntWr && ioReq.data == 8'h00;
    endsequence
    sequence s_rdLocked;
        ioReq.rd && ioReq.addr == 16'h002f && key_q != 2'h2;
    endsequence
    sequence s_lockedForce;
        datWr && key_q != 2'h2 && ioReq.data[5] && !timeoutOut;
    endsequence
    a_status_same: assert property (timeoutOut == timeoutStatus)
        else $error("status flag differs from timeout output");
    a_force_sets: assert property (frcWr |=> timeoutOut)
        else $error("forced timeout missing");
    a_expiry_holds: assert property (timeoutOut && !cntWr |=> timeoutOut)
        else $error("timeout dropped without count write");
    a_count_clears: assert property (cntWr |=> !timeoutOut)
        else $error("count write did not clear timeout");
    a_locked_ignore: assert property (s_lockedForce |=> !timeoutOut)
        else $error("locked write took effect");
    a_rd_holds: assert property (!(ioReq.rd && ioReq.addr == 16'h002f) |=> $stable(ioRdData))
        else $error("read data changed without read");
    a_locked_read: assert property (s_rdLocked |=> ioRdData == 8'hff)
        else $error("locked read not ff");
    a_zero_stops: assert property (s_zeroWr |=> !timeoutOut [*3])
        else $error("zero count timed out");
endmodule // wdt_checker
bind indexed_watchdog_timer wdt_checker chk (.clock(clock), .nrst(nrst), .ioReq(ioReq),
    .ioRdData(ioRdData), .kbdActivity(kbdActivity), .mouseActivity(mouseActivity),
    .timeoutOut(timeoutOut), .timeoutStatus(timeoutStatus));

// ===== dv/indexed_watchdog_timer_tb.sv
`timescale 1ns/1ps
module indexed_watchdog_timer_tb;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    wdt_pkg::io_req_type ioReq = '0;
    logic [7:0] ioRdData;
    logic kbdActivity = 1'b0;
    logic mouseActivity = 1'b0;
    logic timeoutOut, timeoutStatus;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    always #25 clock = ~clock;
    indexed_watchdog_timer #(.MS_CYCLES(4)) DUT (.clock(clock), .nrst(nrst), .ioReq(ioReq),
        .ioRdData(ioRdData), .kbdActivity(kbdActivity), .mouseActivity(mouseActivity),
        .timeoutOut(timeoutOut), .timeoutStatus(timeoutStatus));
    task end_sim;
        $display("compares %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim;
        end
    end
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t read %h want %h", $time, got, exp);
        end
    endtask
    task chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        ioReq <= '{wr: w, rd: !w, addr: a, data: d};
        @(posedge clock);
        ioReq <= '0;
    endtask
    task wrReg(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b1, 16'h002e, idx);
        acc(1'b1, 16'h002f, d);
    endtask
    task rdReg(input logic [7:0] idx, input logic [7:0] exp);
        acc(1'b1, 16'h002e, idx);
        acc(1'b0, 16'h002f, 8'h00);
        @(posedge clock);
        #1 chk8(ioRdData, exp);
    endtask
    task open;
        acc(1'b1, 16'h002e, 8'h87);
        acc(1'b1, 16'h002e, 8'h87);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // cycles from the last count write until timeout, within lo..hi
    task expTo(input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (timeoutOut !== 1'b1 && n <= hi) begin
            @(posedge clock);
            #1 n++;
        end
        chk1(n >= lo && n <= hi, 1'b1);
    endtask
    task pulse(input logic m, input int n);
        repeat (n) begin
            @(posedge clock);
            if (m) mouseActivity <= 1'b1;
            else kbdActivity <= 1'b1;
            @(posedge clock);
            mouseActivity <= 1'b0;
            kbdActivity <= 1'b0;
            repeat (6) @(posedge clock);
        end
        #1;
    endtask
    int lim [3] = '{4, 240, 4000};
    logic [7:0] unit [3] = '{8'h10, 8'h18, 8'h00};
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        #1 chk1(timeoutOut, 1'b0);
        rdReg(8'hf6, 8'hff);
        acc(1'b1, 16'h002e, 8'h87);
        acc(1'b1, 16'h002f, 8'h00);
        acc(1'b1, 16'h002e, 8'h87);
        rdReg(8'h07, 8'hff);
        acc(1'b1, 16'h002e, 8'haa);
        open;
        wrReg(8'hf6, 8'h05);
        rdReg(8'hf6, 8'h00);
        wrReg(8'h07, 8'h08);
        rdReg(8'h07, 8'h08);
        rdReg(8'h30, 8'h00);
        rdReg(8'hf6, 8'h00);
        rdReg(8'hf7, 8'h00);
        wrReg(8'hf5, 8'h10);
        wrReg(8'hf6, 8'h03);
        idle(20);
        chk1(timeoutOut, 1'b0);
        rdReg(8'hf6, 8'h03);
        wrReg(8'h30, 8'h01);
        wrReg(8'hf6, 8'h03);
        expTo(12, 14);
        rdReg(8'hf7, 8'h10);
        wrReg(8'hf6, 8'h02);
        #1 chk1(timeoutOut, 1'b0);
        // rewrite lands one cycle before the old count would expire
        idle(3);
        wrReg(8'hf6, 8'h02);
        expTo(8, 10);
        wrReg(8'hf6, 8'h00);
        idle(30);
        chk1(timeoutOut, 1'b0);
        for (int i = 0; i < 2; i++) begin
            wrReg(8'hf7, i ? 8'h80 : 8'h40);
            // second pass still carries the expiry of the first
            rdReg(8'hf7, i ? 8'h90 : 8'h40);
            wrReg(8'hf6, 8'h03);
            pulse(i[0], 6);
            chk1(timeoutOut, 1'b0);
            pulse(!i[0], 3);
            chk1(timeoutOut, 1'b1);
        end
        for (int i = 0; i < 3; i++) begin
            wrReg(8'hf5, unit[i]);
            wrReg(8'hf6, 8'h01);
            expTo(lim[i], lim[i] + 2);
        end
        // minutes: must outlast one second unit
        wrReg(8'hf5, 8'h08);
        wrReg(8'hf6, 8'h01);
        idle(4010);
        chk1(timeoutOut, 1'b0);
        wrReg(8'hf6, 8'h00);
        acc(1'b1, 16'h002e, 8'haa);
        wrReg(8'hf7, 8'h20);
        idle(2);
        chk1(timeoutOut, 1'b0);
        open;
        wrReg(8'hf7, 8'h20);
        #1 chk1(timeoutOut, 1'b1);
        chk1(timeoutStatus, 1'b1);
        rdReg(8'hf7, 8'h10);
        end_sim;
    end
endmodule // indexed_watchdog_timer_tb
